/* design/irs_pkg.sv */
// Package with the constants and types of the integrator reset and output steering block.
// Contract
// - Error flag low when measurement outlasts watchdog
// - Single mode always drives output A
// - Alternating modes switch output each cycle
// - Two-wire: A while a, B while b
// - Four-wire: B on a&~b, A on c&~d
// - Mode pin and sync_in_d select mode
// - Single variant resets on a XOR b
// - Dual variant resets on any decode
// - Held option: reset follows decode exactly
// - Timed option: timer holds reset, minimum 150ns
// - Calibration holds waves low and reset high, ignores inputs
// - First input starts reset, measure follows
`default_nettype none
package irs_pkg;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned RST_MIN_NS = 150;
	localparam logic [15:0] RST_MIN_CYC = 16'((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int unsigned WD_LIMIT_NS = 10000;
	localparam logic [15:0] WD_LIMIT_CYC = 16'(WD_LIMIT_NS / CLK_PERIOD_NS);
	localparam int unsigned CAL_TIME_NS = 20000;
	localparam int unsigned CAL_CYC_DEF = CAL_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned TMR_W = 16;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RST_TIME = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam int unsigned CTRL_TIMED = 0;
	localparam int unsigned CTRL_ERR_EN = 1;
	localparam int unsigned CTRL_SINGLE = 2;
	localparam logic [2:0] CTRL_RST = 3'h2;
	localparam logic [15:0] RST_TIME_RST = 16'h0026;
	localparam int unsigned IRQ_FAULT = 0;
	localparam int unsigned IRQ_MEAS = 1;
	localparam int unsigned IRQ_CAL = 2;
	localparam int unsigned IRQ_W = 3;
	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} irs_sync_t;
	typedef enum logic [1:0] {
		IRS_MODE_SINGLE,
		IRS_MODE_TWO,
		IRS_MODE_FOUR
	} irs_mode_t;
endpackage
`default_nettype wire

/* design/irs_timer.sv */
// Loadable down counter used for the reset hold, the watchdog and calibration.
`default_nettype none
module irs_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [irs_pkg::TMR_W-1:0] load_val,
	input wire logic en,
	output logic zero
);
	import irs_pkg::*;
	logic [TMR_W-1:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (en && cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
	assign zero = (cnt_r == '0);
endmodule
`default_nettype wire

/* design/irs_steer.sv */
// Integrator reset decode, output steering and watchdog with an APB register file.
`default_nettype none
module irs_steer #(
	parameter int unsigned CAL_CYC = irs_pkg::CAL_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire irs_pkg::irs_sync_t sync_in,
	input wire logic mode_pin,
	output logic integ_reset,
	output logic current_wave_a,
	output logic current_wave_b,
	output logic reset_timing_error_n,
	output logic irq
);
	import irs_pkg::*;

	typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_RESET, ST_MEAS} irs_state_t;

	irs_state_t state_r, state_nxt;
	logic [2:0] ctrl_r;
	logic [15:0] rst_time_r;
	logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, irq_r;
	logic integ_r, wave_a_r, wave_b_r, fault_r, fault_n_r;
	logic dec, dec_q_r, trig, cal_loaded_r;
	logic rst_zero, wd_zero, cal_zero;
	logic [15:0] rst_load_val;
	irs_mode_t mode;
	logic acc, wr_ok, map_hit;
	logic timed, err_en, single_var;

	assign timed = ctrl_r[CTRL_TIMED];
	assign err_en = ctrl_r[CTRL_ERR_EN];
	assign single_var = ctrl_r[CTRL_SINGLE];

	// Mode pin low with sync_in_d low is single, with it high two-wire; mode pin high is four-wire.
	always_comb begin
		if (single_var) begin
			mode = IRS_MODE_SINGLE;
		end else if (mode_pin) begin
			mode = IRS_MODE_FOUR;
		end else if (sync_in.d) begin
			mode = IRS_MODE_TWO;
		end else begin
			mode = IRS_MODE_SINGLE;
		end
	end

	// The decode always picks the function of the active mode, so one path serves all three.
	always_comb begin
		unique case (mode)
			IRS_MODE_SINGLE: dec = sync_in.a ^ sync_in.b;
			IRS_MODE_TWO: dec = !sync_in.a && !sync_in.b;
			IRS_MODE_FOUR: dec = !(sync_in.a && !sync_in.b) && !(sync_in.c && !sync_in.d);
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_q_r <= 1'b0;
		end else begin
			dec_q_r <= dec;
		end
	end

	// Timed option triggers on the decode edge so a long decode does not retrigger endlessly.
	assign trig = timed ? (dec && !dec_q_r) : dec;

	// Hold times below the minimum are clamped rather than refused.
	assign rst_load_val = (rst_time_r < RST_MIN_CYC) ? RST_MIN_CYC : rst_time_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_loaded_r <= 1'b0;
		end else if (state_r == ST_CAL) begin
			cal_loaded_r <= 1'b1;
		end
	end

	irs_timer u_cal (
		.pclk(pclk),
		.presetn(presetn),
		.load(state_r == ST_CAL && !cal_loaded_r),
		.load_val(TMR_W'(CAL_CYC)),
		.en(state_r == ST_CAL),
		.zero(cal_zero)
	);

	irs_timer u_hold (
		.pclk(pclk),
		.presetn(presetn),
		.load(timed && state_r != ST_RESET && state_nxt == ST_RESET),
		.load_val(rst_load_val),
		.en(state_r == ST_RESET),
		.zero(rst_zero)
	);

	irs_timer u_wd (
		.pclk(pclk),
		.presetn(presetn),
		.load(state_r == ST_RESET && state_nxt == ST_MEAS),
		.load_val(WD_LIMIT_CYC),
		.en(state_r == ST_MEAS),
		.zero(wd_zero)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_CAL: begin
				if (cal_loaded_r && cal_zero) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (trig) begin
					state_nxt = ST_RESET;
				end
			end
			ST_RESET: begin
				if (timed ? rst_zero : !dec) begin
					state_nxt = ST_MEAS;
				end
			end
			ST_MEAS: begin
				if (trig) begin
					state_nxt = ST_RESET;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_CAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			integ_r <= 1'b1;
		end else begin
			integ_r <= (state_nxt != ST_MEAS);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else if (state_nxt != ST_MEAS) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			unique case (mode)
				IRS_MODE_SINGLE: begin
					wave_a_r <= 1'b1;
					wave_b_r <= 1'b0;
				end
				IRS_MODE_TWO: begin
					wave_a_r <= sync_in.a;
					wave_b_r <= sync_in.b;
				end
				IRS_MODE_FOUR: begin
					wave_a_r <= sync_in.c && !sync_in.d;
					wave_b_r <= sync_in.a && !sync_in.b;
				end
			endcase
		end
	end

	// The flag rises when the watchdog runs out mid-measurement and falls after a good cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_r <= 1'b0;
		end else if (state_r == ST_MEAS && wd_zero) begin
			fault_r <= 1'b1;
		end else if (state_r == ST_MEAS && state_nxt == ST_RESET) begin
			fault_r <= 1'b0;
		end
	end

	// The shared pin only works as an error output when the error enable bit of ctrl is set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_n_r <= 1'b1;
		end else begin
			fault_n_r <= !(fault_r && err_en);
		end
	end

	assign irq_evt[IRQ_FAULT] = (state_r == ST_MEAS) && wd_zero && !fault_r;
	assign irq_evt[IRQ_MEAS] = (state_r == ST_RESET) && (state_nxt == ST_MEAS);
	assign irq_evt[IRQ_CAL] = (state_r == ST_CAL) && (state_nxt == ST_IDLE);

	// One wait state lets read data and pready come from flip-flops.
	assign acc = psel && penable;
	assign wr_ok = acc && pready_r && pwrite && map_hit;

	always_comb begin
		map_hit = 1'b1;
		unique case (paddr)
			OFS_CTRL, OFS_RST_TIME, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: map_hit = 1'b1;
			default: map_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= acc && !pready_r;
			pslverr_r <= acc && !pready_r && !map_hit;
			prdata_r <= 32'h0;
			if (acc && !pready_r && !pwrite) begin
				unique case (paddr)
					OFS_CTRL: prdata_r <= {29'h0, ctrl_r};
					OFS_RST_TIME: prdata_r <= {16'h0, rst_time_r};
					OFS_STATUS: prdata_r <= {26'h0, mode, fault_r, integ_r,
						state_r != ST_CAL, state_r == ST_MEAS};
					OFS_IRQ_STAT: prdata_r <= {29'h0, irq_stat_r};
					OFS_IRQ_MASK: prdata_r <= {29'h0, irq_mask_r};
					default: prdata_r <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			rst_time_r <= RST_TIME_RST;
			irq_mask_r <= '0;
		end else if (wr_ok) begin
			if (paddr == OFS_CTRL) begin
				ctrl_r <= pwdata[2:0];
			end
			if (paddr == OFS_RST_TIME) begin
				rst_time_r <= pwdata[15:0];
			end
			if (paddr == OFS_IRQ_MASK) begin
				irq_mask_r <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// A new event in the clearing cycle survives because the set term is ORed in last.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else if (wr_ok && paddr == OFS_IRQ_STAT) begin
			irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_evt;
		end else begin
			irq_stat_r <= irq_stat_r | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign integ_reset = integ_r;
	assign current_wave_a = wave_a_r;
	assign current_wave_b = wave_b_r;
	assign reset_timing_error_n = fault_n_r;
	assign irq = irq_r;

	// Checks.
	sequence s_meas_start;
		state_r == ST_RESET ##1 state_r == ST_MEAS;
	endsequence

	a_cal_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_CAL |=> !current_wave_a && !current_wave_b && integ_reset)
		else $error("outputs active during calibration");

	a_single_out: assert property (@(posedge pclk) disable iff (!presetn)
		state_nxt == ST_MEAS && mode == IRS_MODE_SINGLE |=> current_wave_a && !current_wave_b)
		else $error("single mode not on output a");

	a_two_wire: assert property (@(posedge pclk) disable iff (!presetn)
		state_nxt == ST_MEAS && mode == IRS_MODE_TWO
		|=> current_wave_a == $past(sync_in.a) && current_wave_b == $past(sync_in.b))
		else $error("two-wire steering wrong");

	a_four_wire: assert property (@(posedge pclk) disable iff (!presetn)
		state_nxt == ST_MEAS && mode == IRS_MODE_FOUR && sync_in.a && !sync_in.b
		|=> current_wave_b)
		else $error("four-wire output b missing");

	a_four_wire_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_nxt == ST_MEAS && mode == IRS_MODE_FOUR && sync_in.c && !sync_in.d
		|=> current_wave_a)
		else $error("four-wire output a missing");

	// Both inputs low is the two-wire dead time, so the integrator must be held there.
	a_two_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!timed && state_r != ST_CAL && mode == IRS_MODE_TWO && !sync_in.a && !sync_in.b
		|=> integ_reset)
		else $error("two-wire decode did not reset");

	a_held_follow: assert property (@(posedge pclk) disable iff (!presetn)
		!timed && state_r == ST_RESET && !dec |=> !integ_reset)
		else $error("held reset outlasts decode");

	a_timed_min: assert property (@(posedge pclk) disable iff (!presetn)
		timed && $rose(integ_reset) |-> integ_reset [*8])
		else $error("timed reset too short");

	a_wd_restart: assert property (@(posedge pclk) disable iff (!presetn)
		s_meas_start |-> !wd_zero)
		else $error("watchdog not restarted");

	a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_MEAS && wd_zero && err_en |=> ##1 !reset_timing_error_n)
		else $error("error flag not raised");

	a_first_reset: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_IDLE && trig |=> state_r == ST_RESET ##0 integ_reset)
		else $error("first input did not start reset");

	a_single_xor: assert property (@(posedge pclk) disable iff (!presetn)
		!timed && state_r != ST_CAL && mode == IRS_MODE_SINGLE && (sync_in.a ^ sync_in.b)
		|=> integ_reset)
		else $error("single decode not xor");
endmodule
`default_nettype wire

/* tb/irs_ctrl_model.sv */
// Power stage controller model that drives the four gate timing lines.
`default_nettype none
module irs_ctrl_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire irs_pkg::irs_mode_t mode,
	input wire logic [15:0] rst_len,
	input wire logic [15:0] meas_len,
	output var irs_pkg::irs_sync_t sync_in,
	output logic meas,
	output logic leg
);
	timeunit 1ns;
	timeprecision 1ps;
	import irs_pkg::*;
	logic [15:0] cnt_r;
	// Phase lengths come from the bench so it can stretch a measurement on purpose.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			meas <= 1'b1;
			leg <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			if (cnt_r + 16'h0001 >= (meas ? meas_len : rst_len)) begin
				cnt_r <= 16'h0000;
				meas <= !meas;
				leg <= meas ? leg : !leg;
			end
		end
	end
	always_comb begin
		case (mode)
			IRS_MODE_TWO: sync_in = meas ? (leg ? 4'b0101 : 4'b1001) : 4'b0001;
			IRS_MODE_FOUR: sync_in = meas ? (leg ? 4'b0110 : 4'b1001) : 4'b0101;
			default: sync_in = meas ? 4'b0000 : 4'b1000;
		endcase
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the integrator reset and output steering block.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irs_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mode_pin = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, integ_reset, wave_a, wave_b, err_n, irq, meas, leg, err;
	logic [15:0] rst_len = 16'h0008, meas_len = 16'h0008, hold;
	irs_mode_t pmode = IRS_MODE_SINGLE;
	irs_sync_t sync_in;
	int mismatches = 0, checked = 0, seed = 81, n;
	always #2 pclk = ~pclk;
	irs_steer #(.CAL_CYC(20)) dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in(sync_in),
		.mode_pin(mode_pin), .integ_reset(integ_reset), .current_wave_a(wave_a),
		.current_wave_b(wave_b), .reset_timing_error_n(err_n), .irq(irq));
	irs_ctrl_model partner(.pclk(pclk), .presetn(presetn), .mode(pmode),
		.rst_len(rst_len), .meas_len(meas_len), .sync_in(sync_in), .meas(meas),
		.leg(leg));
	task end_of_test;
		if (mismatches == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task wait_lvl(input logic m);
		int k;
		k = 0;
		while (meas !== m) begin
			@(posedge pclk);
			k++;
			if (k > 5000) begin
				mismatches++;
				end_of_test();
			end
		end
	endtask
	// Waiting for the opposite level first makes every wait land on a fresh phase.
	task wait_start(input logic m);
		wait_lvl(!m);
		wait_lvl(m);
	endtask
	function automatic logic [1:0] exp_wave(irs_mode_t m, logic l);
		case (m)
			IRS_MODE_TWO: return l ? 2'b01 : 2'b10;
			IRS_MODE_FOUR: return l ? 2'b10 : 2'b01;
			default: return 2'b10;
		endcase
	endfunction
	task run_cycles(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			rst_len <= 16'd5 + 16'($unsigned($random(seed)) % 16);
			meas_len <= 16'd6 + 16'($unsigned($random(seed)) % 60);
			wait_start(0);
			repeat (3) @(posedge pclk);
			#1;
			chk("reset", {integ_reset, wave_a, wave_b}, 3'b100);
			wait_start(1);
			repeat (3) @(posedge pclk);
			#1;
			chk("steer", {integ_reset, wave_a, wave_b}, {1'b0, exp_wave(pmode, leg)});
		end
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_STATUS, 0);
		chk("cal_done", {31'h0, rd[1]}, 0);
		#1;
		chk("cal_hold", {integ_reset, wave_a, wave_b}, 3'b100);
		apb(0, OFS_CTRL, 0);
		chk("ctrl", rd, {29'h0, CTRL_RST});
		apb(0, OFS_RST_TIME, 0);
		chk("rst_time", rd, {16'h0, RST_TIME_RST});
		apb(0, 8'h14, 0);
		chk("unmapped", {rd[30:0], err}, 1);
		n = $random(seed);
		apb(1, OFS_IRQ_MASK, n);
		apb(0, OFS_IRQ_MASK, 0);
		chk("mask", rd, 32'(n) & 32'h7);
		apb(1, OFS_IRQ_MASK, 0);
		for (int m = 0; m < 3; m++) begin
			pmode <= irs_mode_t'(m);
			mode_pin <= (m == 2);
			run_cycles(6);
			apb(0, OFS_STATUS, 0);
			chk("mode", {30'h0, rd[5:4]}, 32'(m));
		end
		pmode <= IRS_MODE_SINGLE;
		apb(1, OFS_CTRL, 32'h6);
		run_cycles(2);
		apb(0, OFS_STATUS, 0);
		chk("variant", {30'h0, rd[5:4]}, 32'h0);
		mode_pin <= 1'b0;
		apb(1, OFS_CTRL, {29'h0, CTRL_RST});
		apb(0, OFS_IRQ_STAT, 0);
		chk("irq_evt", rd, 32'h6);
		apb(1, OFS_IRQ_STAT, 32'h7);
		// Stretching only from a reset phase keeps the current measurement short.
		wait_start(0);
		meas_len <= 16'd2600;
		wait_start(1);
		n = 0;
		while (err_n !== 1'b0 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk("wd_time", 32'(n > 2494 && n < 2511), 1);
		#1;
		chk("irq_off", {31'h0, irq}, 0);
		apb(1, OFS_IRQ_MASK, 32'h1);
		meas_len <= 16'd50;
		wait_start(0);
		wait_start(1);
		wait_start(0);
		repeat (4) @(posedge pclk);
		#1;
		chk("err_clear", {30'h0, err_n, irq}, 32'h3);
		apb(1, OFS_IRQ_STAT, 32'h1);
		apb(0, OFS_IRQ_STAT, 0);
		chk("w1c", {31'h0, rd[0]}, 0);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq_clr", {31'h0, irq}, 0);
		apb(1, OFS_CTRL, 32'h3);
		for (int v = 0; v < 2; v++) begin
			hold = 16'($unsigned($random(seed)) % 38) + (v ? 16'd38 : 16'd0);
			apb(1, OFS_RST_TIME, {16'h0, hold});
			hold = (hold < 16'd38) ? 16'd38 : hold;
			rst_len <= 16'd4;
			meas_len <= 16'd200;
			wait_start(0);
			repeat (hold - 3) @(posedge pclk);
			#1;
			chk("timed_hold", {31'h0, integ_reset}, 1);
			repeat (7) @(posedge pclk);
			#1;
			chk("timed_end", {integ_reset, wave_a}, 2'b01);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
